// ===== src/jhl_defines.svh
// constants for the jitter hit event logger: field positions, limits, reset values
// assumes inclusion by bare name from every file that needs the numbers
`ifndef JHL_DEFINES_SVH
`define JHL_DEFINES_SVH
`define JHL_SEC_W        32
`define JHL_AMP_W        16
`define JHL_CNT_W        32
`define JHL_THR_MIN      16'h0001
`define JHL_THR_MAX      16'h3E80
`define JHL_STOP_OPEN    32'hFFFFFFFF
`define JHL_ZERO_SEC     32'h00000000
`define JHL_ZERO_AMP     16'h0000
`define JHL_ZERO_CNT     32'h00000000
`define JHL_ONE_CNT      32'h00000001
`define JHL_SETUP_W      10
`define JHL_SU_RATE_LO   0
`define JHL_SU_INPUT_LO  2
`define JHL_SU_REF       4
`define JHL_SU_HPF_LO    5
`define JHL_SU_MODE      9
`define JHL_RATE_52      2'h0
`define JHL_RATE_155     2'h1
`define JHL_RATE_622     2'h2
`define JHL_IN_CLOCK     2'h0
`define JHL_IN_DATA      2'h1
`define JHL_IN_OPTICAL   2'h2
`endif

// ===== src/jhl_pkg.sv
// types shared by the jitter hit event logger and its record memory
// assumes jhl_defines.svh is on the include path
`include "jhl_defines.svh"
package jhl_pkg;
	typedef struct packed {
		logic [`JHL_SEC_W-1:0] start_sec;
		logic [`JHL_SEC_W-1:0] stop_sec;
		logic [`JHL_AMP_W-1:0] max_amp;
	} jhl_rec_type;

	typedef enum logic [1:0] {
		RS_IDLE  = 2'b00,
		RS_SETUP = 2'b01,
		RS_FETCH = 2'b10,
		RS_LINE  = 2'b11
	} jhl_rep_state_type;
endpackage

// ===== src/jhl_rec_if.sv
// carrier between the logger and its hit record memory
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface jhl_rec_if
	import jhl_pkg::*;
	#(parameter int IDX_W = 4);
	logic              we;
	logic [IDX_W-1:0]  waddr;
	jhl_rec_type       wdata;
	logic [IDX_W-1:0]  raddr_a;
	jhl_rec_type       rdata_a;
	logic [IDX_W-1:0]  raddr_b;
	jhl_rec_type       rdata_b;
	modport logger (output we, output waddr, output wdata, output raddr_a,
		input rdata_a, output raddr_b, input rdata_b);
	modport mem (input we, input waddr, input wdata, input raddr_a,
		output rdata_a, input raddr_b, output rdata_b);
endinterface

// ===== src/jhl_rec_mem.sv
// hit record store: one write port, two registered read ports
// assumes a single clock; contents are not cleared, the logger gates the report by count but not the view port
`timescale 1ns/1ns
module jhl_rec_mem
	import jhl_pkg::*;
	#(parameter int DEPTH = 16,
	  parameter int IDX_W = 4)
	(input  wire logic  i_clock,
	 jhl_rec_if.mem     port);

	jhl_rec_type mem_r [DEPTH];

	always_ff @(posedge i_clock)
	begin
		if (port.we)
			mem_r[port.waddr] <= port.wdata;
	end

	// read ports carry no reset so the array can map onto ram
	always_ff @(posedge i_clock)
	begin
		port.rdata_a <= mem_r[port.raddr_a];
		port.rdata_b <= mem_r[port.raddr_b];
	end
endmodule // jhl_rec_mem

// ===== src/jhl_logger.sv
// jitter hit event logger: per-second threshold test, counters, hit records,
// hit report sequencer, single-point mtie and tdev accumulation
// assumes i_second_tick is a one-cycle pulse from the internal time base
`timescale 1ns/1ns
`include "jhl_defines.svh"
// Summary of operation
// RULE_01: count seconds whose peak-to-peak exceeded threshold
// RULE_02: count each run of jitter seconds once
// RULE_03: count all seconds since last clear
// RULE_04: store start, stop, max per event
// RULE_05: start time is first jitter second
// RULE_06: stop time is first clean second after
// RULE_07: clear or reset restarts measurement interval
// RULE_08: report gives one line per recorded event
// RULE_09: report opens with receiver setup line
// RULE_10: mtie and tdev for one configured time
// RULE_11: wander results update on every sample; tdev here updates only when a block of i_integration_time samples completes
// RULE_12: test max peak-to-peak per one-second window
// RULE_13: threshold clamped to 0.001 to 16 UI
// RULE_14: seconds bounded by internal tick only
// RULE_15: flag full storage, keep counting, no overwrite
module jhl_logger
	import jhl_pkg::*;
	#(parameter int DEPTH = 16,
	  parameter int IDX_W = 4,
	  parameter int TIE_W = 16)
	(input  wire logic                    i_clock,
	 input  wire logic                    i_resetn,
	 input  wire logic                    i_meas_clear,
	 input  wire logic                    i_second_tick,
	 input  wire logic                    i_pp_valid,
	 input  wire logic [`JHL_AMP_W-1:0]   i_pp_jitter,
	 input  wire logic [`JHL_AMP_W-1:0]   i_threshold,
	 input  wire logic [1:0]              i_rx_rate,
	 input  wire logic [1:0]              i_rx_input,
	 input  wire logic                    i_ref_external,
	 input  wire logic [3:0]              i_hpf_cutoff,
	 input  wire logic                    i_fine_mode,
	 input  wire logic [IDX_W-1:0]        i_view_index,
	 output logic [`JHL_SEC_W-1:0]        o_view_start,
	 output logic [`JHL_SEC_W-1:0]        o_view_stop,
	 output logic [`JHL_AMP_W-1:0]        o_view_max,
	 output logic [`JHL_CNT_W-1:0]        o_threshold_second_count,
	 output logic [`JHL_CNT_W-1:0]        o_hit_event_count,
	 output logic [`JHL_SEC_W-1:0]        o_elapsed_seconds,
	 output logic                         o_in_event,
	 output logic                         o_storage_full,
	 output logic [`JHL_AMP_W-1:0]        o_threshold_applied,
	 input  wire logic                    i_report_req,
	 input  wire logic                    i_report_ready,
	 output logic                         o_report_valid,
	 output logic                         o_report_setup,
	 output logic [IDX_W:0]               o_report_line,
	 output logic [`JHL_SETUP_W-1:0]      o_report_setup_word,
	 output logic [`JHL_SEC_W-1:0]        o_report_start,
	 output logic [`JHL_SEC_W-1:0]        o_report_stop,
	 output logic [`JHL_AMP_W-1:0]        o_report_max,
	 input  wire logic                    i_tie_valid,
	 input  wire logic signed [TIE_W-1:0] i_tie,
	 input  wire logic [15:0]             i_observation_time,
	 input  wire logic [7:0]              i_integration_time,
	 output logic [TIE_W:0]               o_mtie,
	 output logic [63:0]                  o_tdev_sq_sum,
	 output logic [31:0]                  o_tdev_terms);

	localparam logic [`JHL_CNT_W-1:0] DEPTH_CNT = `JHL_CNT_W'(DEPTH);

	jhl_rec_if #(.IDX_W(IDX_W)) rec ();
	jhl_rec_mem #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_mem (.i_clock(i_clock), .port(rec.mem));

	logic [`JHL_AMP_W-1:0] thr;
	logic [`JHL_AMP_W-1:0] sec_max_r;
	logic [`JHL_AMP_W-1:0] sec_peak;
	logic                  jitter_sec;
	logic [`JHL_CNT_W-1:0] jsec_cnt_r;
	logic [`JHL_CNT_W-1:0] hit_cnt_r;
	logic [`JHL_SEC_W-1:0] elapsed_r;
	logic                  in_event_r;
	logic [`JHL_SEC_W-1:0] ev_start_r;
	logic [`JHL_AMP_W-1:0] ev_max_r;
	logic [`JHL_AMP_W-1:0] ev_max_nxt;
	logic [`JHL_CNT_W-1:0] ev_idx;
	logic                  full_r;

	always_comb
	begin
		if (i_threshold < `JHL_THR_MIN)
			thr = `JHL_THR_MIN; // [RULE_13]
		else if (i_threshold > `JHL_THR_MAX)
			thr = `JHL_THR_MAX; // [RULE_13]
		else
			thr = i_threshold;
	end

	// a sample landing on the tick still belongs to the closing second
	assign sec_peak   = (i_pp_valid && i_pp_jitter > sec_max_r) ? i_pp_jitter : sec_max_r;
	assign jitter_sec = sec_peak > thr; // [RULE_12]
	assign ev_max_nxt = (in_event_r && ev_max_r > sec_peak) ? ev_max_r : sec_peak;
	// index of the record being built: the open event, or the one about to open
	assign ev_idx     = in_event_r ? hit_cnt_r - `JHL_ONE_CNT : hit_cnt_r;

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			sec_max_r <= `JHL_ZERO_AMP;
		else if (i_meas_clear || i_second_tick) // [RULE_14]
			sec_max_r <= `JHL_ZERO_AMP; // [RULE_12]
		else
			sec_max_r <= sec_peak;
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			elapsed_r  <= `JHL_ZERO_SEC;
			jsec_cnt_r <= `JHL_ZERO_CNT;
			hit_cnt_r  <= `JHL_ZERO_CNT;
			in_event_r <= 1'b0;
			ev_start_r <= `JHL_ZERO_SEC;
			ev_max_r   <= `JHL_ZERO_AMP;
		end
		else if (i_meas_clear)
		begin
			elapsed_r  <= `JHL_ZERO_SEC; // [RULE_07]
			jsec_cnt_r <= `JHL_ZERO_CNT;
			hit_cnt_r  <= `JHL_ZERO_CNT;
			in_event_r <= 1'b0;
			ev_start_r <= `JHL_ZERO_SEC;
			ev_max_r   <= `JHL_ZERO_AMP;
		end
		else if (i_second_tick)
		begin
			elapsed_r <= elapsed_r + `JHL_ONE_CNT; // [RULE_03]
			if (jitter_sec)
			begin
				jsec_cnt_r <= jsec_cnt_r + `JHL_ONE_CNT; // [RULE_01]
				ev_max_r   <= ev_max_nxt;
				if (!in_event_r)
				begin
					hit_cnt_r  <= hit_cnt_r + `JHL_ONE_CNT; // [RULE_02]
					ev_start_r <= elapsed_r; // [RULE_05]
					in_event_r <= 1'b1;
				end
			end
			else
				in_event_r <= 1'b0;
		end
	end

	// the record is rewritten every second of an event so an open one can be viewed
	always_comb
	begin
		rec.we          = i_second_tick && !i_meas_clear && (jitter_sec || in_event_r)
			&& ev_idx < DEPTH_CNT; // [RULE_15]
		rec.waddr       = ev_idx[IDX_W-1:0];
		rec.wdata.start_sec = in_event_r ? ev_start_r : elapsed_r; // [RULE_04] [RULE_05]
		rec.wdata.stop_sec  = jitter_sec ? `JHL_STOP_OPEN : elapsed_r; // [RULE_06]
		rec.wdata.max_amp   = ev_max_nxt; // [RULE_04]
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			full_r <= 1'b0;
		else if (i_meas_clear)
			full_r <= 1'b0;
		else if (hit_cnt_r >= DEPTH_CNT)
			full_r <= 1'b1; // [RULE_15]
	end

	assign rec.raddr_a = i_view_index;
	assign o_view_start = rec.rdata_a.start_sec;
	assign o_view_stop  = rec.rdata_a.stop_sec;
	assign o_view_max   = rec.rdata_a.max_amp;
	assign o_threshold_second_count = jsec_cnt_r;
	assign o_hit_event_count = hit_cnt_r;
	assign o_elapsed_seconds = elapsed_r;
	assign o_in_event = in_event_r;
	assign o_storage_full = full_r;
	assign o_threshold_applied = thr;

	// report sequencer
	jhl_rep_state_type     rep_state_r;
	logic [IDX_W:0]        rep_idx_r;
	logic [IDX_W:0]        rep_total_r;
	logic [`JHL_SETUP_W-1:0] setup_r;

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rep_state_r <= RS_IDLE;
			rep_idx_r   <= '0;
			rep_total_r <= '0;
			setup_r     <= '0;
		end
		else
		begin
			unique case (rep_state_r)
				RS_IDLE:
					if (i_report_req)
					begin
						rep_state_r <= RS_SETUP;
						rep_idx_r   <= '0;
						// only stored events can be listed
						rep_total_r <= (hit_cnt_r > DEPTH_CNT) ? (IDX_W+1)'(DEPTH)
							: hit_cnt_r[IDX_W:0]; // [RULE_08]
						setup_r[`JHL_SU_RATE_LO+:2]  <= i_rx_rate; // [RULE_09]
						setup_r[`JHL_SU_INPUT_LO+:2] <= i_rx_input;
						setup_r[`JHL_SU_REF]         <= i_ref_external;
						setup_r[`JHL_SU_HPF_LO+:4]   <= i_hpf_cutoff;
						setup_r[`JHL_SU_MODE]        <= i_fine_mode;
					end
				RS_SETUP:
					if (i_report_ready)
						rep_state_r <= (rep_total_r == '0) ? RS_IDLE : RS_FETCH;
				RS_FETCH:
					rep_state_r <= RS_LINE;
				RS_LINE:
					if (i_report_ready)
					begin
						rep_idx_r   <= rep_idx_r + 1'b1;
						rep_state_r <= (rep_idx_r + 1'b1 == rep_total_r) ? RS_IDLE
							: RS_FETCH; // [RULE_08]
					end
			endcase
		end
	end

	assign rec.raddr_b         = rep_idx_r[IDX_W-1:0];
	assign o_report_valid      = rep_state_r == RS_SETUP || rep_state_r == RS_LINE;
	assign o_report_setup      = rep_state_r == RS_SETUP;
	assign o_report_line       = rep_idx_r;
	assign o_report_setup_word = setup_r;
	assign o_report_start      = rec.rdata_b.start_sec;
	assign o_report_stop       = rec.rdata_b.stop_sec;
	assign o_report_max        = rec.rdata_b.max_amp;

	// mtie over successive windows of i_observation_time samples
	logic signed [TIE_W-1:0] w_max_r;
	logic signed [TIE_W-1:0] w_min_r;
	logic signed [TIE_W-1:0] n_max;
	logic signed [TIE_W-1:0] n_min;
	logic [15:0]             w_cnt_r;
	logic [TIE_W:0]          span;
	logic [TIE_W:0]          mtie_r;

	assign n_max = (w_cnt_r == 16'h0000 || i_tie > w_max_r) ? i_tie : w_max_r;
	assign n_min = (w_cnt_r == 16'h0000 || i_tie < w_min_r) ? i_tie : w_min_r;
	assign span  = (TIE_W+1)'({n_max[TIE_W-1], n_max} - {n_min[TIE_W-1], n_min});

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			w_max_r <= '0;
			w_min_r <= '0;
			w_cnt_r <= 16'h0000;
			mtie_r  <= '0;
		end
		else if (i_meas_clear)
		begin
			w_cnt_r <= 16'h0000;
			mtie_r  <= '0;
		end
		else if (i_tie_valid)
		begin
			w_max_r <= n_max;
			w_min_r <= n_min;
			// window restarts after its last sample; a zero setting acts as one
			w_cnt_r <= (w_cnt_r + 16'h0001 >= i_observation_time) ? 16'h0000
				: w_cnt_r + 16'h0001; // [RULE_10]
			if (span > mtie_r)
				mtie_r <= span; // [RULE_11]
		end
	end
	assign o_mtie = mtie_r;

	// tdev numerator: squared second difference of block sums, one block per integration time
	localparam int SUM_W = TIE_W + 8;
	logic signed [SUM_W-1:0]   blk_acc_r;
	logic signed [SUM_W-1:0]   blk_a_r;
	logic signed [SUM_W-1:0]   blk_b_r;
	logic signed [SUM_W-1:0]   blk_now;
	logic signed [SUM_W+1:0]   dd;
	logic [7:0]                blk_cnt_r;
	logic [1:0]                blk_have_r;
	logic [63:0]               sq_sum_r;
	logic [31:0]               terms_r;
	logic                      blk_done;

	assign blk_now  = blk_acc_r + SUM_W'(i_tie);
	assign blk_done = i_tie_valid && (blk_cnt_r + 8'h01 >= i_integration_time);
	assign dd = (SUM_W+2)'(blk_now) - ((SUM_W+2)'(blk_b_r) <<< 1) + (SUM_W+2)'(blk_a_r);

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			blk_acc_r  <= '0;
			blk_a_r    <= '0;
			blk_b_r    <= '0;
			blk_cnt_r  <= 8'h00;
			blk_have_r <= 2'h0;
			sq_sum_r   <= 64'h0000000000000000;
			terms_r    <= 32'h00000000;
		end
		else if (i_meas_clear)
		begin
			blk_acc_r  <= '0;
			blk_cnt_r  <= 8'h00;
			blk_have_r <= 2'h0;
			sq_sum_r   <= 64'h0000000000000000;
			terms_r    <= 32'h00000000;
		end
		else if (i_tie_valid)
		begin
			blk_acc_r <= blk_done ? '0 : blk_now;
			blk_cnt_r <= blk_done ? 8'h00 : blk_cnt_r + 8'h01; // [RULE_10]
			if (blk_done)
			begin
				blk_a_r <= blk_b_r;
				blk_b_r <= blk_now;
				if (blk_have_r == 2'h2)
				begin
					// widen before squaring so the product cannot wrap at the sum width
					sq_sum_r <= sq_sum_r + 64'(dd) * 64'(dd); // [RULE_11]
					terms_r  <= terms_r + 32'h00000001;
				end
				else
					blk_have_r <= blk_have_r + 2'h1;
			end
		end
	end
	assign o_tdev_sq_sum = sq_sum_r;
	assign o_tdev_terms  = terms_r;

	sequence s_report_req;
		rep_state_r == RS_IDLE && i_report_req;
	endsequence
	sequence s_setup_shown;
		o_report_valid && o_report_setup;
	endsequence

	property p_jsec_count;
		@(posedge i_clock) disable iff (!i_resetn)
		i_second_tick && !i_meas_clear && jitter_sec |=> jsec_cnt_r == $past(jsec_cnt_r) + 1;
	endproperty
	a_jsec_count: assert property (p_jsec_count) else $error("jitter second not counted"); // [RULE_01]
	property p_hit_once;
		@(posedge i_clock) disable iff (!i_resetn)
		i_second_tick && !i_meas_clear && jitter_sec && in_event_r |=> $stable(hit_cnt_r);
	endproperty
	a_hit_once: assert property (p_hit_once) else $error("hit counted twice in one run"); // [RULE_02]
	property p_elapsed;
		@(posedge i_clock) disable iff (!i_resetn)
		!i_meas_clear |=> elapsed_r == $past(elapsed_r) + ($past(i_second_tick) ? 1 : 0);
	endproperty
	a_elapsed: assert property (p_elapsed) else $error("elapsed seconds wrong"); // [RULE_03] [RULE_14]
	property p_start;
		@(posedge i_clock) disable iff (!i_resetn)
		i_second_tick && !i_meas_clear && jitter_sec && !in_event_r && hit_cnt_r < DEPTH_CNT
		|-> rec.we && rec.wdata.start_sec == elapsed_r;
	endproperty
	a_start: assert property (p_start) else $error("event start not recorded"); // [RULE_05]
	property p_stop;
		@(posedge i_clock) disable iff (!i_resetn)
		i_second_tick && !i_meas_clear && !jitter_sec && in_event_r && hit_cnt_r <= DEPTH_CNT
		|-> rec.we && rec.wdata.stop_sec == elapsed_r ##1 !in_event_r;
	endproperty
	a_stop: assert property (p_stop) else $error("event stop not recorded"); // [RULE_06]
	property p_clear;
		@(posedge i_clock) disable iff (!i_resetn)
		i_meas_clear |=> hit_cnt_r == 0 && jsec_cnt_r == 0 && elapsed_r == 0 && !full_r;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not restart interval"); // [RULE_07]
	property p_report_start;
		@(posedge i_clock) disable iff (!i_resetn)
		s_report_req |=> s_setup_shown;
	endproperty
	a_report_start: assert property (p_report_start) else $error("setup line missing"); // [RULE_09]
	property p_line_range;
		@(posedge i_clock) disable iff (!i_resetn)
		o_report_valid && !o_report_setup |-> o_report_line < rep_total_r;
	endproperty
	a_line_range: assert property (p_line_range) else $error("report line past last event"); // [RULE_08]
	property p_mtie_mono;
		@(posedge i_clock) disable iff (!i_resetn)
		!i_meas_clear |=> mtie_r >= $past(mtie_r);
	endproperty
	a_mtie_mono: assert property (p_mtie_mono) else $error("mtie decreased"); // [RULE_11]
	property p_thr_range;
		@(posedge i_clock) disable iff (!i_resetn)
		o_threshold_applied >= `JHL_THR_MIN && o_threshold_applied <= `JHL_THR_MAX;
	endproperty
	a_thr_range: assert property (p_thr_range) else $error("threshold out of range"); // [RULE_13]
	property p_full;
		@(posedge i_clock) disable iff (!i_resetn)
		hit_cnt_r >= DEPTH_CNT && !i_meas_clear |=> full_r && !(rec.we && !in_event_r);
	endproperty
	a_full: assert property (p_full) else $error("storage full not handled"); // [RULE_15]
endmodule // jhl_logger

// ===== bench/jhl_front_model.sv
// far-side model: front end giving peak and tie samples and second ticks, plus
// the report reader; drives 5 ns after each rising edge of the one clock
`timescale 1ns/1ns
module jhl_front_model
	(input  wire logic        i_clock,
	 input  wire logic        i_slow,
	 output logic             o_second_tick,
	 output logic             o_pp_valid,
	 output logic [15:0]      o_pp_jitter,
	 output logic             o_report_ready,
	 output logic             o_tie_valid,
	 output logic [15:0]      o_tie);
	logic [1:0] pace_r;
	initial
	begin
		{o_second_tick, o_pp_valid, o_report_ready, o_tie_valid, pace_r} = 6'h00;
		{o_pp_jitter, o_tie} = 32'h00000000;
	end
	// a slow reader accepts one cycle in four, so each line must stand meanwhile
	always @(posedge i_clock)
	begin
		#5;
		pace_r = pace_r + 2'h1;
		o_report_ready = !i_slow || pace_r == 2'h0;
	end
	task automatic pulse_tick;
		o_second_tick = 1'b1;
		@(posedge i_clock);
		#5;
		o_second_tick = 1'b0;
	endtask
	// the peak sample lands in the tick cycle; idle data is inverted, never stale
	task automatic run_second(input logic [15:0] peak);
		@(posedge i_clock);
		#5;
		o_pp_valid = 1'b1;
		o_pp_jitter = peak >> 1;
		@(posedge i_clock);
		#5;
		o_pp_jitter = peak;
		pulse_tick();
		o_pp_valid = 1'b0;
		o_pp_jitter = ~peak;
	endtask
	task automatic tie_sample(input logic [15:0] v);
		@(posedge i_clock);
		#5;
		o_tie_valid = 1'b1;
		o_tie = v;
		@(posedge i_clock);
		#5;
		o_tie_valid = 1'b0;
		o_tie = ~v;
	endtask
endmodule // jhl_front_model

// ===== bench/jhl_logger_test.sv
// self-checking bench for the jitter hit event logger: counters, records, report,
// wander, clamp and clear; assumes jhl_front_model drives the far side
`timescale 1ns/1ns
`include "jhl_defines.svh"
module jhl_logger_test;
	import jhl_pkg::*;
	localparam int DEPTH = 4;
	localparam bit [15:0] PAT = 16'hD5CB;
	localparam logic [15:0] THR_IN[5] = '{16'h0000, 16'h0001, 16'h3E80, 16'h3E81, 16'hFFFF};
	localparam logic [15:0] THR_OUT[5] = '{`JHL_THR_MIN, `JHL_THR_MIN, `JHL_THR_MAX,
		`JHL_THR_MAX, `JHL_THR_MAX};
	typedef struct {
		logic        setup;
		logic [9:0]  word;
		logic [2:0]  line;
		logic [31:0] start;
		logic [31:0] stop;
		logic [15:0] amp;
	} jhl_note_type;
	logic        i_clock, i_resetn, i_meas_clear, i_second_tick, i_pp_valid, i_tie_valid;
	logic        i_ref_external, i_fine_mode, i_report_req, i_report_ready, slow;
	logic        o_in_event, o_storage_full, o_report_valid, o_report_setup;
	logic [1:0]  i_rx_rate, i_rx_input, i_view_index;
	logic [2:0]  o_report_line;
	logic [3:0]  i_hpf_cutoff;
	logic [7:0]  i_integration_time;
	logic [9:0]  o_report_setup_word;
	logic [15:0] i_pp_jitter, i_threshold, i_tie, i_observation_time;
	logic [15:0] o_view_max, o_threshold_applied, o_report_max, rm[8];
	logic [16:0] o_mtie;
	logic [31:0] o_view_start, o_view_stop, o_threshold_second_count, o_hit_event_count;
	logic [31:0] o_elapsed_seconds, o_report_start, o_report_stop, o_tdev_terms;
	logic [31:0] rnd, rs[8], rp[8];
	logic [63:0] o_tdev_sq_sum;
	int          n_mismatch, n_tests, el, jsec, hits;
	bit          in_ev;
	jhl_note_type notes[$];
	jhl_note_type got_note;
	jhl_logger #(.DEPTH(DEPTH), .IDX_W(2), .TIE_W(16)) DUT (
		.i_clock, .i_resetn, .i_meas_clear, .i_second_tick, .i_pp_valid, .i_pp_jitter,
		.i_threshold, .i_rx_rate, .i_rx_input, .i_ref_external, .i_hpf_cutoff, .i_fine_mode,
		.i_view_index, .o_view_start, .o_view_stop, .o_view_max, .o_threshold_second_count,
		.o_hit_event_count, .o_elapsed_seconds, .o_in_event, .o_storage_full,
		.o_threshold_applied, .i_report_req, .i_report_ready, .o_report_valid,
		.o_report_setup, .o_report_line, .o_report_setup_word, .o_report_start,
		.o_report_stop, .o_report_max, .i_tie_valid, .i_tie, .i_observation_time,
		.i_integration_time, .o_mtie, .o_tdev_sq_sum, .o_tdev_terms);
	jhl_front_model m (.i_clock, .i_slow(slow), .o_second_tick(i_second_tick),
		.o_pp_valid(i_pp_valid), .o_pp_jitter(i_pp_jitter), .o_report_ready(i_report_ready),
		.o_tie_valid(i_tie_valid), .o_tie(i_tie));
	initial
	begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	// the whole run needs under 200 cycles
	initial
	begin
		repeat (6000) @(posedge i_clock);
		n_mismatch++;
		wrap_up();
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// a line is taken at the next rising edge while valid and ready are both high
	always @(negedge i_clock)
		if (o_report_valid === 1'b1 && i_report_ready === 1'b1)
		begin
			check("report line expected", notes.size() > 0, 1'b1);
			got_note = notes.pop_front();
			check("setup flag", o_report_setup, got_note.setup);
			if (got_note.setup)
				check("setup word", o_report_setup_word, got_note.word);
			else
			begin
				check("line index", o_report_line, got_note.line);
				check("line start stop", {o_report_start, o_report_stop},
					{got_note.start, got_note.stop});
				check("line max", o_report_max, got_note.amp);
			end
		end
	task automatic counts;
		check("jitter seconds", o_threshold_second_count, jsec);
		check("hit events", o_hit_event_count, hits);
		check("elapsed", o_elapsed_seconds, el);
		check("in event", o_in_event, in_ev);
		check("storage full", o_storage_full, hits >= DEPTH);
	endtask
	// clean seconds sometimes sit exactly on the threshold, which is not a hit
	task automatic sec(input bit hit);
		logic [15:0] pk;
		rnd = lfsr(rnd);
		pk = hit ? i_threshold + 16'h0001 + {8'h00, rnd[7:0]} : {5'h00, rnd[10:0]};
		if (!hit && rnd[0])
			pk = i_threshold;
		m.run_second(pk);
		if (hit)
		begin
			if (!in_ev)
			begin
				hits++;
				rs[hits-1] = el;
				rm[hits-1] = pk;
			end
			rm[hits-1] = pk > rm[hits-1] ? pk : rm[hits-1];
			rp[hits-1] = `JHL_STOP_OPEN;
			jsec++;
		end
		else if (in_ev)
			rp[hits-1] = el;
		in_ev = hit;
		el++;
		@(posedge i_clock);
		#5;
		counts();
	endtask
	task automatic report(input int k);
		rnd = lfsr(rnd);
		{i_rx_rate, i_rx_input, i_ref_external, i_fine_mode} = {k[1:0], 2'(2 - k), k[0], ~k[0]};
		i_hpf_cutoff = rnd[3:0];
		slow = k[0];
		notes.push_back(jhl_note_type'{1'b1, {i_fine_mode, i_hpf_cutoff, i_ref_external,
			i_rx_input, i_rx_rate}, 3'h0, 32'h0, 32'h0, 16'h0});
		for (int j = 0; j < hits && j < DEPTH; j++)
			notes.push_back(jhl_note_type'{1'b0, 10'h000, j[2:0], rs[j], rp[j], rm[j]});
		// held for two cycles: the second cycle arrives while busy and is ignored
		i_report_req = 1'b1;
		repeat (2) @(posedge i_clock);
		#5;
		i_report_req = 1'b0;
		for (int t = 0; t < 100 && notes.size() > 0; t++)
			@(posedge i_clock);
		repeat (4) @(posedge i_clock);
		#5;
		check("report lines left", notes.size(), 0);
	endtask
	// mtie windows restart every win_len samples; tdev blocks hold blk_len samples
	task automatic wander(input int win_len, input int blk_len);
		int b[3];
		int lo, hi, x, acc, nb, mt, nt, d;
		longint sq;
		{lo, hi, x, acc, nb, mt, nt, d, sq} = '0;
		b = '{0, 0, 0};
		i_observation_time = 16'(win_len);
		i_integration_time = 8'(blk_len);
		for (int k = 0; k < 10; k++)
		begin
			rnd = lfsr(rnd);
			x = int'(signed'(rnd[11:0]));
			m.tie_sample(16'(x));
			lo = (k % win_len == 0 || x < lo) ? x : lo;
			hi = (k % win_len == 0 || x > hi) ? x : hi;
			mt = hi - lo > mt ? hi - lo : mt;
			acc += x;
			if (k % blk_len == blk_len - 1)
			begin
				b = '{b[1], b[2], acc};
				acc = 0;
				nb++;
				d = b[2] - 2 * b[1] + b[0];
				sq += nb >= 3 ? longint'(d) * d : 64'sd0;
				nt += nb >= 3 ? 1 : 0;
			end
			check("mtie", o_mtie, mt);
			check("tdev sum", o_tdev_sq_sum, sq);
			check("tdev terms", o_tdev_terms, nt);
		end
	endtask
	initial
	begin
		rnd = 32'h09F4F21B;
		{i_resetn, i_meas_clear, i_report_req, slow, i_ref_external, i_fine_mode} = 6'h00;
		{i_rx_rate, i_rx_input, i_view_index, i_hpf_cutoff, i_integration_time} = 18'h00001;
		i_threshold = 16'h0800;
		i_observation_time = 16'hFFFF;
		repeat (2) @(posedge i_clock);
		#5;
		i_resetn = 1'b1;
		counts();
		foreach (THR_IN[k])
		begin
			i_threshold = THR_IN[k];
			#1;
			check("threshold", o_threshold_applied, THR_OUT[k]);
		end
		i_threshold = 16'h0800;
		wander(65535, 1);
		for (int k = 0; k < 16; k++)
			sec(PAT[k]);
		for (int k = 0; k < DEPTH; k++)
		begin
			i_view_index = k[1:0];
			@(posedge i_clock);
			#5;
			check("view record", {o_view_start, o_view_stop}, {rs[k], rp[k]});
			check("view max", o_view_max, rm[k]);
		end
		report(0);
		report(1);
		// a clear in the tick cycle wins, so that second is lost
		i_meas_clear = 1'b1;
		m.pulse_tick();
		i_meas_clear = 1'b0;
		{el, jsec, hits, in_ev} = '0;
		@(posedge i_clock);
		#5;
		counts();
		check("wander cleared", {o_mtie, o_tdev_terms}, 64'h0);
		check("tdev sum cleared", o_tdev_sq_sum, 64'h0);
		wander(3, 2);
		sec(1'b1);
		sec(1'b0);
		report(2);
		wrap_up();
	end
endmodule // jhl_logger_test
